// ### src/bzc_codec_ctrl.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - tx substitution disable 0 gives zero substitution plus AMI; 1 gives AMI only.
// - excessive-zero insert enable gates excessive-zero insertion.
// - violation insert enable gates bipolar violation insertion.
// - with source select 0, a rise of the trigger bit inserts one enabled error each.
// - trigger must return to 0 before another error; several toggles give one.
// - source select chooses trigger bit (0) or external manual pin (1).
// - changing source select while a trigger is high may insert an error.
// - code-violation select counts E3 line code violations instead of plain violations.
// - line code violation is two consecutive same-polarity violations; ignored in B3ZS.
// - error detection format 0: zero+violation is B3ZS, two zeros+violation HDB3.
// - error detection format 1 also needs polarity opposite the previous signature.
// - first signature after reset is recognised without the polarity condition.
// - decode format bit applies the same recognition choice to the decoder.
// - rx substitution disable 0 removes substitutions; 1 does AMI decode only.
// - excessive-zero count status is 1 while that count is nonzero.
// - violation count status is 1 while that count is nonzero.
// - loss-of-signal status follows the condition, forced clear while decoding is disabled.
// - signature latched bit sets on any detected substitution signature.
// - excessive-zero latched bit sets on each excessive-zero event.
// - excessive-zero count latched bit sets when its status bit rises.
// - violation latched bit sets on violation, or line code violation when selected.
// - violation count latched bit sets when its status bit rises.
// - loss-of-signal latched bit sets on every change of its status.
// - a latched bit interrupts only with its enable and the port enable set.
// - 16-bit violation count, copied to the readable register on monitor update.
`include "bzc_cfg.svh"
module bzc_codec_ctrl (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic datapath_reset_pin_n_i,
  input wire logic e3_mode_i,
  input wire logic port_irq_enable_field_i,
  input wire logic perf_monitor_update_i,
  input wire logic manual_error_pin_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic bit_tick_o,
  input wire logic tx_data_i,
  output logic tx_pos_o,
  output logic tx_neg_o,
  input wire logic rx_pos_i,
  input wire logic rx_neg_i,
  output logic rx_data_o,
  output logic irq_o
);
  import bzc_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] run_len(input logic e3);
    run_len = e3 ? `BZC_RUN_HDB3 : `BZC_RUN_B3ZS;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic inc);
    sat_inc = (inc && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  localparam logic [7:0] BIT_DIV_M1 = 8'(`BZC_BIT_DIV - 1);

  logic [4:0] tx_ctl;
  logic [3:0] rx_ctl;
  logic [5:0] rx_ie;
  logic [5:0] rx_lat;
  logic [15:0] viol_acc;
  logic [15:0] exz_acc;
  logic [15:0] viol_cnt;
  logic [15:0] exz_cnt;
  logic viol_nz;
  logic exz_nz;
  logic signal_lost;
  bzc_bus_st_t bus_st;
  logic [7:0] div_cnt;

  // ************************************************************
  // bit-rate divider
  // ************************************************************
  // one clock domain: every line bit is a single-cycle tick
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt <= 8'h00;
      bit_tick_o <= 1'b0;
    end else begin
      bit_tick_o <= (div_cnt == BIT_DIV_M1);
      div_cnt <= (div_cnt == BIT_DIV_M1) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // ************************************************************
  // register bus slave
  // ************************************************************
  logic [7:0] reg_idx;
  logic wr_lo;
  logic [31:0] next_rdata;
  assign reg_idx = avs_address_i[9:2];
  assign wr_lo = (bus_st == BZC_BUS_ACK) && avs_write_i && avs_byteenable_i[0];

  // read mux; unmapped words read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_idx)
      `BZC_IDX_TX_CTL: next_rdata[4:0] = tx_ctl;
      `BZC_IDX_RX_CTL: next_rdata[3:0] = rx_ctl;
      `BZC_IDX_RX_STS: next_rdata[5:0] = {2'b00, exz_nz, 1'b0, viol_nz, signal_lost};
      `BZC_IDX_RX_LAT: next_rdata[5:0] = rx_lat;
      `BZC_IDX_RX_IE: next_rdata[5:0] = rx_ie;
      `BZC_IDX_VIOL_CNT: next_rdata[15:0] = viol_cnt;
      `BZC_IDX_EXZ_CNT: next_rdata[15:0] = exz_cnt;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // wait one cycle, then complete with waitrequest low for exactly one cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_st <= BZC_BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      unique case (bus_st)
        BZC_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_st <= BZC_BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= avs_read_i ? next_rdata : 32'h0000_0000;
          end
        end
        BZC_BUS_ACK: begin
          bus_st <= BZC_BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // control registers take writes at the completing edge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ctl <= `BZC_TX_CTL_RST;
      rx_ctl <= `BZC_RX_CTL_RST;
      rx_ie <= `BZC_RX_IE_RST;
    end else if (wr_lo) begin
      if (reg_idx == `BZC_IDX_TX_CTL) tx_ctl <= avs_writedata_i[4:0];
      if (reg_idx == `BZC_IDX_RX_CTL) rx_ctl <= avs_writedata_i[3:0];
      if (reg_idx == `BZC_IDX_RX_IE) rx_ie <= avs_writedata_i[5:0];
    end
  end

  // ************************************************************
  // transmit error insertion
  // ************************************************************
  logic trig_sel;
  logic trig_q;
  logic bpv_pend;
  logic exz_pend;
  logic [2:0] exz_left;
  logic tx_slot_bpv;
  logic tx_slot_exz;
  // trigger mux sits ahead of the edge detector, so a select flip under a high trigger can fire
  assign trig_sel = tx_ctl[`BZC_TX_SRC_SEL] ? manual_error_pin_i : tx_ctl[`BZC_TX_SINGLE_TRIG];

  // pending requests collapse repeated rises into one error per slot
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trig_q <= 1'b0;
      bpv_pend <= 1'b0;
      exz_pend <= 1'b0;
    end else begin
      trig_q <= trig_sel;
      if (!tx_ctl[`BZC_TX_VIOL_INS_EN]) bpv_pend <= 1'b0;
      else if (trig_sel && !trig_q) bpv_pend <= 1'b1;
      else if (tx_slot_bpv) bpv_pend <= 1'b0;
      if (!tx_ctl[`BZC_TX_EXZ_INS_EN]) exz_pend <= 1'b0;
      else if (trig_sel && !trig_q) exz_pend <= 1'b1;
      else if (tx_slot_exz) exz_pend <= 1'b0;
    end
  end

  AST_BPV_ARMS: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (trig_sel && !trig_q && tx_ctl[`BZC_TX_VIOL_INS_EN] && !tx_slot_bpv) |=> bpv_pend)
    else $error("rising trigger did not arm violation insertion");
  AST_NO_EXZ_WHEN_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !tx_ctl[`BZC_TX_EXZ_INS_EN] |=> !exz_pend)
    else $error("excessive zero insertion armed while disabled");

  // ************************************************************
  // transmit encoder
  // ************************************************************
  bzc_sym_t tx_st [4];
  logic tx_odd;
  logic tx_last_pos;
  logic tx_sub;
  logic [2:0] tx_len;
  assign tx_len = run_len(e3_mode_i);
  // a zero run of full length is replaced while substitution is on
  assign tx_sub = !tx_ctl[`BZC_TX_SUBST_DIS] && !tx_data_i && tx_st[0] == BZC_SYM_ZERO &&
                  tx_st[1] == BZC_SYM_ZERO && (tx_len == `BZC_RUN_B3ZS || tx_st[2] == BZC_SYM_ZERO);
  assign tx_slot_exz = bit_tick_o && exz_left == 3'd0 && exz_pend;
  assign tx_slot_bpv = bit_tick_o && exz_left == 3'd0 && !exz_pend && tx_st[3] != BZC_SYM_ZERO;

  // four-symbol look-ahead line so a substitution can rewrite its leading zero
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st <= '{BZC_SYM_ZERO, BZC_SYM_ZERO, BZC_SYM_ZERO, BZC_SYM_ZERO};
      tx_odd <= 1'b0;
    end else if (bit_tick_o) begin
      tx_st[3] <= tx_st[2];
      tx_st[2] <= tx_st[1];
      tx_st[1] <= tx_st[0];
      tx_st[0] <= tx_data_i ? BZC_SYM_MARK : BZC_SYM_ZERO;
      tx_odd <= tx_odd ^ tx_data_i;
      if (tx_sub) begin
        // odd pulses since last violation: plain zeros then V; even: balancing B first
        tx_st[0] <= BZC_SYM_VIOL;
        tx_odd <= 1'b0;
        if (tx_len == `BZC_RUN_B3ZS) tx_st[2] <= tx_odd ? BZC_SYM_ZERO : BZC_SYM_MARK;
        else tx_st[3] <= tx_odd ? BZC_SYM_ZERO : BZC_SYM_MARK;
      end
    end
  end

  // line drive; an inserted zero run overwrites symbols, trading data for a clean error
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
      tx_last_pos <= 1'b0;
      exz_left <= 3'd0;
    end else if (bit_tick_o) begin
      tx_pos_o <= 1'b0;
      tx_neg_o <= 1'b0;
      if (exz_left != 3'd0) begin
        exz_left <= exz_left - 3'd1;
      end else if (exz_pend) begin
        exz_left <= tx_len - 3'd1;
      end else if (tx_st[3] != BZC_SYM_ZERO) begin
        // a violation repeats the last polarity; an inserted error flips the choice
        if ((tx_st[3] == BZC_SYM_VIOL) ^ bpv_pend) begin
          tx_pos_o <= tx_last_pos;
          tx_neg_o <= !tx_last_pos;
        end else begin
          tx_pos_o <= !tx_last_pos;
          tx_neg_o <= tx_last_pos;
          tx_last_pos <= !tx_last_pos;
        end
      end
    end
  end

  AST_TX_NEVER_BOTH: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !(tx_pos_o && tx_neg_o))
    else $error("transmit drives both rails");

  // ************************************************************
  // receive decoder and detectors
  // ************************************************************
  logic rx_pulse;
  logic rx_bpv;
  logic [1:0] rx_zh;
  logic rx_seen;
  logic rx_last_pos;
  logic sig_base;
  logic err_sig;
  logic dec_sig;
  logic err_seen;
  logic err_pol;
  logic dec_seen;
  logic dec_pol;
  logic cv_seen;
  logic cv_pol;
  logic viol_err;
  logic cnt_ev;
  logic exz_ev;
  logic [7:0] zrun;
  logic [2:0] rx_d;
  logic subst_on;
  assign subst_on = !rx_ctl[`BZC_RX_SUBST_DIS];
  assign rx_pulse = rx_pos_i || rx_neg_i;
  assign rx_bpv = bit_tick_o && rx_pulse && rx_seen && (rx_pos_i == rx_last_pos);
  // one zero then a violation for B3ZS, two zeros for HDB3
  assign sig_base = rx_bpv && rx_zh[0] && (!e3_mode_i || rx_zh[1]);
  assign err_sig = sig_base && (!rx_ctl[`BZC_RX_ERR_FMT] || !err_seen || rx_pos_i != err_pol);
  assign dec_sig = sig_base && (!rx_ctl[`BZC_RX_DEC_FMT] || !dec_seen || rx_pos_i != dec_pol);
  assign viol_err = rx_bpv && !(err_sig && subst_on);
  // same-polarity pair of errors only counts in HDB3 with the option on
  assign cnt_ev = (e3_mode_i && rx_ctl[`BZC_RX_CV_SEL]) ?
                  (viol_err && cv_seen && rx_pos_i == cv_pol) : viol_err;
  assign exz_ev = bit_tick_o && !rx_pulse && (zrun == {5'd0, run_len(e3_mode_i)} - 8'd1);

  // pulse history and signature polarity memory; datapath reset restarts the first-signature case
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_zh <= 2'b00;
      rx_seen <= 1'b0;
      rx_last_pos <= 1'b0;
      err_seen <= 1'b0;
      err_pol <= 1'b0;
      dec_seen <= 1'b0;
      dec_pol <= 1'b0;
      cv_seen <= 1'b0;
      cv_pol <= 1'b0;
      zrun <= 8'h00;
    end else if (!datapath_reset_pin_n_i) begin
      rx_seen <= 1'b0;
      err_seen <= 1'b0;
      dec_seen <= 1'b0;
      cv_seen <= 1'b0;
      zrun <= 8'h00;
    end else if (bit_tick_o) begin
      rx_zh <= {rx_zh[0], !rx_pulse};
      if (rx_pulse) begin
        rx_seen <= 1'b1;
        rx_last_pos <= rx_pos_i;
        zrun <= 8'h00;
      end else if (zrun != 8'hff) begin
        zrun <= zrun + 8'h01;
      end
      if (err_sig) begin
        err_seen <= 1'b1;
        err_pol <= rx_pos_i;
      end
      if (dec_sig) begin
        dec_seen <= 1'b1;
        dec_pol <= rx_pos_i;
      end
      if (viol_err) begin
        cv_seen <= 1'b1;
        cv_pol <= rx_pos_i;
      end
    end
  end

  // decoded data pipe; a recognised signature is zeroed back to its first bit
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_d <= 3'b000;
      rx_data_o <= 1'b0;
    end else if (bit_tick_o) begin
      rx_data_o <= rx_d[2];
      rx_d <= {rx_d[1:0], rx_pulse};
      if (dec_sig && subst_on) begin
        rx_d[1:0] <= 2'b00;
        if (e3_mode_i) rx_data_o <= 1'b0;
        else rx_d[2] <= 1'b0;
        rx_d[0] <= 1'b0;
      end
    end
  end

  // loss of signal: long zero run, cleared on the first pulse, held off when decoding is off
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      signal_lost <= 1'b0;
    end else if (!subst_on) begin
      signal_lost <= 1'b0;
    end else if (bit_tick_o) begin
      if (rx_pulse) signal_lost <= 1'b0;
      else if (zrun >= `BZC_LOS_ZEROS) signal_lost <= 1'b1;
    end
  end

  AST_LOS_OFF: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (!subst_on ##1 !subst_on) |-> !signal_lost)
    else $error("loss of signal shown while decoding is disabled");

  // ************************************************************
  // counters
  // ************************************************************
  // live counts are copied to the readable registers and restarted on each update
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      viol_acc <= 16'h0000;
      exz_acc <= 16'h0000;
      viol_cnt <= 16'h0000;
      exz_cnt <= 16'h0000;
      viol_nz <= 1'b0;
      exz_nz <= 1'b0;
    end else if (perf_monitor_update_i) begin
      viol_cnt <= sat_inc(viol_acc, cnt_ev);
      exz_cnt <= sat_inc(exz_acc, exz_ev);
      viol_nz <= (sat_inc(viol_acc, cnt_ev) != 16'h0000);
      exz_nz <= (sat_inc(exz_acc, exz_ev) != 16'h0000);
      viol_acc <= 16'h0000;
      exz_acc <= 16'h0000;
    end else begin
      viol_acc <= sat_inc(viol_acc, cnt_ev);
      exz_acc <= sat_inc(exz_acc, exz_ev);
    end
  end

  AST_VIOL_NZ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    viol_nz == (viol_cnt != 16'h0000))
    else $error("violation count status disagrees with count");
  AST_EXZ_NZ: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    exz_nz == (exz_cnt != 16'h0000))
    else $error("excessive zero count status disagrees with count");

  // ************************************************************
  // latched status and interrupt
  // ************************************************************
  logic los_q;
  logic [5:0] lat_set;
  logic [5:0] lat_clr;
  assign lat_set[`BZC_ST_SIG] = sig_base;
  assign lat_set[`BZC_ST_EXZ] = exz_ev;
  assign lat_set[`BZC_ST_EXZ_NZ] = perf_monitor_update_i && !exz_nz &&
                                   (sat_inc(exz_acc, exz_ev) != 16'h0000);
  assign lat_set[`BZC_ST_VIOL] = cnt_ev;
  assign lat_set[`BZC_ST_VIOL_NZ] = perf_monitor_update_i && !viol_nz &&
                                    (sat_inc(viol_acc, cnt_ev) != 16'h0000);
  assign lat_set[`BZC_ST_LOS] = signal_lost != los_q;
  assign lat_clr = (wr_lo && reg_idx == `BZC_IDX_RX_LAT) ? avs_writedata_i[5:0] : 6'h00;

  // write one to clear; a fresh event in the same cycle keeps the bit set
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_lat <= 6'h00;
      los_q <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      los_q <= signal_lost;
      rx_lat <= (rx_lat & ~lat_clr) | lat_set;
      irq_o <= port_irq_enable_field_i && |(rx_lat & rx_ie);
    end
  end

  AST_LOS_CHANGE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $changed(signal_lost) |=> rx_lat[`BZC_ST_LOS])
    else $error("loss of signal change not latched");
  AST_EXCESS_ZERO_COUNT_NZ_RISE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(exz_nz) |-> rx_lat[`BZC_ST_EXZ_NZ])
    else $error("excessive zero count rise not latched");
  AST_IRQ_GATE: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    irq_o |-> $past(port_irq_enable_field_i) && $past(|(rx_lat & rx_ie)))
    else $error("interrupt raised without both enables");
  AST_BUS_ONE_ACK: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
endmodule

// ### src/bzc_cfg.svh
`ifndef BZC_CFG_SVH
`define BZC_CFG_SVH
// register indices; byte address is four times the index
`define BZC_IDX_TX_CTL 8'h8c
`define BZC_IDX_RX_CTL 8'h90
`define BZC_IDX_RX_STS 8'h94
`define BZC_IDX_RX_LAT 8'h96
`define BZC_IDX_RX_IE 8'h98
`define BZC_IDX_VIOL_CNT 8'h9c
`define BZC_IDX_EXZ_CNT 8'h9e
// line_tx_control fields
`define BZC_TX_SUBST_DIS 4
`define BZC_TX_EXZ_INS_EN 3
`define BZC_TX_VIOL_INS_EN 2
`define BZC_TX_SINGLE_TRIG 1
`define BZC_TX_SRC_SEL 0
// line_rx_control fields
`define BZC_RX_CV_SEL 3
`define BZC_RX_ERR_FMT 2
`define BZC_RX_DEC_FMT 1
`define BZC_RX_SUBST_DIS 0
// status and latched fields
`define BZC_ST_SIG 5
`define BZC_ST_EXZ 4
`define BZC_ST_EXZ_NZ 3
`define BZC_ST_VIOL 2
`define BZC_ST_VIOL_NZ 1
`define BZC_ST_LOS 0
// reset values
`define BZC_TX_CTL_RST 5'h00
`define BZC_RX_CTL_RST 4'h0
`define BZC_RX_IE_RST 6'h00
// timing: one line bit per divider period
`define BZC_CLK_PERIOD_NS 10
`define BZC_BIT_PERIOD_NS 20
`define BZC_BIT_DIV (`BZC_BIT_PERIOD_NS / `BZC_CLK_PERIOD_NS)
// zero runs
`define BZC_RUN_B3ZS 3'd3
`define BZC_RUN_HDB3 3'd4
`define BZC_LOS_ZEROS 8'd175
`endif

// ### src/bzc_pkg.sv
package bzc_pkg;
  // line symbol held in the transmit pipeline
  typedef enum logic [1:0] {
    BZC_SYM_ZERO = 2'h0,
    BZC_SYM_MARK = 2'h1,
    BZC_SYM_VIOL = 2'h2
  } bzc_sym_t;
  // register bus handshake states
  typedef enum logic [1:0] {
    BZC_BUS_IDLE = 2'h1,
    BZC_BUS_ACK = 2'h2
  } bzc_bus_st_t;
endpackage

// ### tb/bzc_line_model.sv
`timescale 1ns/1ps
// ****************************************
// line interface model: cable loop from transmit rails to receive rails
// ****************************************
module bzc_line_model (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic bit_tick_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  output logic rx_pos_o,
  output logic rx_neg_o
);
  // one slot of cable delay; rails move only in bit slots, as a recovered clock sees them
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_pos_o <= 1'b0;
      rx_neg_o <= 1'b0;
    end else if (bit_tick_i) begin
      rx_pos_o <= tx_pos_i;
      rx_neg_o <= tx_neg_i;
    end
  end
endmodule

// ### tb/bzc_codec_ctrl_bench.sv
`timescale 1ns/1ps
`include "bzc_cfg.svh"
module bzc_codec_ctrl_bench;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [9:0] A_TX = {`BZC_IDX_TX_CTL, 2'b00};
  localparam logic [9:0] A_RX = {`BZC_IDX_RX_CTL, 2'b00};
  localparam logic [9:0] A_STS = {`BZC_IDX_RX_STS, 2'b00};
  localparam logic [9:0] A_LAT = {`BZC_IDX_RX_LAT, 2'b00};
  localparam logic [9:0] A_IE = {`BZC_IDX_RX_IE, 2'b00};
  localparam logic [9:0] A_VC = {`BZC_IDX_VIOL_CNT, 2'b00};
  localparam logic [9:0] A_ZC = {`BZC_IDX_EXZ_CNT, 2'b00};
  localparam logic [9:0] A_NONE = 10'h238;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic dp_rst_n = 1'b1;
  logic e3_mode = 1'b0;
  logic port_ie = 1'b0;
  logic perf_upd = 1'b0;
  logic man_pin = 1'b0;
  logic tx_data = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_be = 4'hf;
  logic [31:0] avs_readdata, q, v, e, m;
  logic avs_waitrequest, bit_tick, tx_pos, tx_neg, rx_pos, rx_neg, rx_data, irq;
  logic [4:0] base [4] = '{5'h14, 5'h15, 5'h10, 5'h18};
  logic ev [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic ez [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int fails = 0;
  int n_compared = 0;
  int ones_seen = 0;
  integer seed = 32'h0e7249b8;

  always #5 core_clk_i = ~core_clk_i;
  // decoded ones per bit slot; zeroed on a falling edge to stay clear of this edge's updates
  always @(posedge core_clk_i) if (bit_tick && rx_data === 1'b1) ones_seen++;

  bzc_codec_ctrl DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .datapath_reset_pin_n_i(dp_rst_n),
    .e3_mode_i(e3_mode), .port_irq_enable_field_i(port_ie), .perf_monitor_update_i(perf_upd),
    .manual_error_pin_i(man_pin), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_be),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .bit_tick_o(bit_tick),
    .tx_data_i(tx_data), .tx_pos_o(tx_pos), .tx_neg_o(tx_neg), .rx_pos_i(rx_pos), .rx_neg_i(rx_neg),
    .rx_data_o(rx_data), .irq_o(irq));
  bzc_line_model line (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .bit_tick_i(bit_tick),
    .tx_pos_i(tx_pos), .tx_neg_i(tx_neg), .rx_pos_o(rx_pos), .rx_neg_o(rx_neg));

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples waitrequest low; bounded so a hang ends the run
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
      end_sim();
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q & mask);
  endtask

  task automatic slots(input int n);
    repeat (2 * n) @(posedge core_clk_i);
  endtask

  task automatic pulse_upd;
    @(posedge core_clk_i);
    perf_upd <= 1'b1;
    @(posedge core_clk_i);
    perf_upd <= 1'b0;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rdchk(A_TX, '1, 32'h0, "tx_ctl");
    rdchk(A_RX, '1, 32'h0, "rx_ctl");
    rdchk(A_IE, '1, 32'h0, "rx_ie");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(A_TX, v);
      rdchk(A_TX, '1, v & 32'h1f, "tx_ctl");
      wr(A_RX, v >> 8);
      rdchk(A_RX, '1, (v >> 8) & 32'hf, "rx_ctl");
      wr(A_IE, v >> 16);
      rdchk(A_IE, '1, (v >> 16) & 32'h3f, "rx_ie");
      wr(A_NONE, v);
      rdchk(A_NONE, '1, 32'h0, "unmapped");
      wr(A_VC, v);
      rdchk(A_VC, '1, 32'h0, "viol_cnt");
    end
    wr(A_IE, 32'h0);
    $display("test registers done");
    // all-zero data: substitution keeps pulses on the line, decoder strips them again
    wr(A_TX, 32'h0);
    // B3ZS with decode format 0, then HDB3 with decode format 1; both must strip every pulse
    for (int k = 0; k < 2; k++) begin
      wr(A_RX, 32'h4 + 2 * k);
      e3_mode <= k[0];
      slots(30);
      @(negedge core_clk_i);
      ones_seen = 0;
      slots(100);
      chk("ones_seen", 32'h0, ones_seen);
      rdchk(A_STS, 32'h1, 32'h0, "rx_sts");
      wr(A_LAT, 32'h3f);
      slots(10);
      rdchk(A_LAT, 32'h20, 32'h20, "rx_lat");
    end
    e3_mode <= 1'b0;
    wr(A_TX, 32'h10);
    slots(200);
    rdchk(A_STS, 32'h1, 32'h1, "rx_sts");
    rdchk(A_LAT, 32'h1, 32'h1, "rx_lat");
    wr(A_IE, 32'h1);
    slots(2);
    chk("irq", 32'h0, irq);
    port_ie <= 1'b1;
    slots(2);
    chk("irq", 32'h1, irq);
    wr(A_RX, 32'h1);
    slots(10);
    rdchk(A_STS, 32'h1, 32'h0, "rx_sts");
    wr(A_LAT, 32'h3f);
    rdchk(A_LAT, 32'h1, 32'h0, "rx_lat");
    wr(A_IE, 32'h0);
    slots(2);
    chk("irq", 32'h0, irq);
    $display("test line status done");
    // all-ones data, AMI both ways: each inserted error shows alone
    tx_data <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(A_TX, base[i]);
      slots(20);
      // the first update flushes counts left by earlier tests, the second brings the count status back to zero
      repeat (2) pulse_upd();
      slots(2);
      wr(A_LAT, 32'h3f);
      if (base[i][0]) begin
        man_pin <= 1'b1;
        slots(5);
        man_pin <= 1'b0;
        wr(A_TX, base[i] | 5'h02);
      end else begin
        wr(A_TX, base[i] | 5'h02);
        wr(A_TX, base[i] | 5'h02);
      end
      slots(40);
      wr(A_TX, base[i]);
      pulse_upd();
      slots(2);
      m = (i == 3) ? 32'h18 : 32'h1e;
      e = {27'h0, ez[i], ez[i], ev[i], ev[i], 1'b0};
      rdchk(A_ZC, '1, {31'h0, ez[i]}, "exz_cnt");
      if (i != 3) rdchk(A_VC, '1, {31'h0, ev[i]}, "viol_cnt");
      rdchk(A_LAT, m, e & m, "rx_lat");
      rdchk(A_STS, m & 32'h0a, e & m & 32'h0a, "rx_sts");
      $display("test insertion case %0d done", i);
    end
    end_sim();
  end
endmodule
